/* design/icrl_defs.vh */
`ifndef ICRL_DEFS_VH
`define ICRL_DEFS_VH

// register indices; byte address is four times the index
`define ICRL_IDX_DATA 8'hf3
`define ICRL_IDX_DELAY 8'hf4
`define ICRL_IDX_CTRL 8'hf5
`define ICRL_IDX_SCALE_LO 8'hf6
`define ICRL_IDX_SCALE_HI 8'hf7
`define ICRL_IDX_RSVD_A 8'hf8
`define ICRL_IDX_RSVD_B 8'hf9
`define ICRL_IDX_RSVD_C 8'hfa
`define ICRL_IDX_BYPASS 8'hfb

// control register fields
`define ICRL_CTRL_PROG 0
`define ICRL_CTRL_MATCH 2
`define ICRL_CTRL_DIR 4
`define ICRL_CTRL_MASK 8'h15

// delay register fields
`define ICRL_DLY_PAR_LSB 0
`define ICRL_DLY_HYB_LSB 4

// bypass register fields
`define ICRL_BYP_HYB 0
`define ICRL_BYP_ADC 1
`define ICRL_BYP_MASK 8'h03

// reset values
`define ICRL_RST_DATA 8'h00
`define ICRL_RST_DELAY 8'h00
`define ICRL_RST_CTRL 8'h10
`define ICRL_RST_SCALE 16'h2000
`define ICRL_RST_SCALE_LO 8'h00
`define ICRL_RST_SCALE_HI 8'h20
`define ICRL_RST_RSVD 8'h00
`define ICRL_RST_BYPASS 8'h00

// coefficient memory
`define ICRL_COEF_BYTES 144
`define ICRL_PTR_W 8
`define ICRL_SCALE_FRAC 13

`endif

/* design/icrl_loader.v */
// Notes on behaviour
// - An 8-bit data register at index 0xf3 writes or reads one coefficient byte per access.
// - Control bit 0 enables or disables programming access through the data register.
// - Control bit 2 enables complex impedance matching with the loaded set.
// - Control bit 4 selects direction: 0 reads the coefficient memory, 1 writes it.
// - The low nibble of the delay register sets the parallel path delay, zero at reset.
// - The high nibble of the delay register sets the hybrid path delay, zero at reset.
// - The PCM signal is scaled by a 16-bit 3.13 factor held low byte first in two registers.
// - Bypass bit 0 routes around the hybrid low-pass filter, reset 0 keeps it in.
// - Bypass bit 1 routes around the converter low-pass filter, reset 0 keeps it in.
`include "icrl_defs.vh"
`default_nettype none

module icrl_loader (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [7:0] coef_rd_addr,
	output reg [7:0] coef_rd_data,
	output wire complex_match_enable,
	output wire coef_program_enable,
	output wire coef_access_direction,
	output wire [3:0] parallel_path_delay,
	output wire [3:0] hybrid_path_delay,
	output wire [15:0] pcm_scale_factor,
	output wire hybrid_lpf_bypass,
	output wire converter_lpf_bypass,
	output wire [7:0] coef_pointer,
	input wire [15:0] pcm_in,
	input wire pcm_in_valid,
	output reg [15:0] pcm_out,
	output reg pcm_out_valid
);

	// =====================================================
	// register state
	reg [7:0] coef_ram_data_port;
	reg [7:0] path_delay_counts;
	reg [7:0] coef_ram_control;
	reg [7:0] pcm_scale_low;
	reg [7:0] pcm_scale_high;
	reg [7:0] reserved_a;
	reg [7:0] reserved_b;
	reg [7:0] reserved_c;
	reg [7:0] filter_bypass_control;
	reg [7:0] coef_mem [0:`ICRL_COEF_BYTES-1];
	reg [`ICRL_PTR_W-1:0] ptr;
	integer i;
	reg [7:0] next_rdata;
	reg [`ICRL_PTR_W-1:0] next_ptr;
	reg [8:0] wr_en;

	// =====================================================
	// register select codes
	localparam SEL_DATA = 4'h0;
	localparam SEL_DELAY = 4'h1;
	localparam SEL_CTRL = 4'h2;
	localparam SEL_SCALE_LO = 4'h3;
	localparam SEL_SCALE_HI = 4'h4;
	localparam SEL_RSVD_A = 4'h5;
	localparam SEL_RSVD_B = 4'h6;
	localparam SEL_RSVD_C = 4'h7;
	localparam SEL_BYPASS = 4'h8;
	localparam SEL_NONE = 4'hf;

	// =====================================================
	// address decode
	function hit;
		input [11:0] addr;
		input [7:0] idx;
		begin
			hit = (addr[11:2] == {2'b00, idx}) && (addr[1:0] == 2'b00);
		end
	endfunction

	function mapped;
		input [11:0] addr;
		begin
			mapped = hit(addr, `ICRL_IDX_DATA) |
				hit(addr, `ICRL_IDX_DELAY) |
				hit(addr, `ICRL_IDX_CTRL) |
				hit(addr, `ICRL_IDX_SCALE_LO) |
				hit(addr, `ICRL_IDX_SCALE_HI) |
				hit(addr, `ICRL_IDX_RSVD_A) |
				hit(addr, `ICRL_IDX_RSVD_B) |
				hit(addr, `ICRL_IDX_RSVD_C) |
				hit(addr, `ICRL_IDX_BYPASS);
		end
	endfunction

	// misaligned or out of range maps to none
	function [3:0] sel_of;
		input [11:0] addr;
		begin
			sel_of = SEL_NONE;
			if (addr[1:0] == 2'b00 && addr[11:10] == 2'b00) begin
				case (addr[9:2])
				`ICRL_IDX_DATA: sel_of = SEL_DATA;
				`ICRL_IDX_DELAY: sel_of = SEL_DELAY;
				`ICRL_IDX_CTRL: sel_of = SEL_CTRL;
				`ICRL_IDX_SCALE_LO: sel_of = SEL_SCALE_LO;
				`ICRL_IDX_SCALE_HI: sel_of = SEL_SCALE_HI;
				`ICRL_IDX_RSVD_A: sel_of = SEL_RSVD_A;
				`ICRL_IDX_RSVD_B: sel_of = SEL_RSVD_B;
				`ICRL_IDX_RSVD_C: sel_of = SEL_RSVD_C;
				`ICRL_IDX_BYPASS: sel_of = SEL_BYPASS;
				default: sel_of = SEL_NONE;
				endcase
			end
		end
	endfunction

	wire setup = psel & ~penable;
	wire access = psel & penable;
	wire wr = access & pwrite & mapped(paddr);
	wire rd_setup = setup & ~pwrite;
	wire data_acc = access & hit(paddr, `ICRL_IDX_DATA);

	assign pready = 1'b1;
	assign pslverr = access & ~mapped(paddr);

	assign coef_program_enable = coef_ram_control[`ICRL_CTRL_PROG];
	assign complex_match_enable = coef_ram_control[`ICRL_CTRL_MATCH];
	assign coef_access_direction = coef_ram_control[`ICRL_CTRL_DIR];
	assign coef_pointer = ptr;

	wire ptr_live = coef_program_enable & (ptr < `ICRL_COEF_BYTES);
	wire mem_wr = wr & data_acc & ptr_live & coef_access_direction;
	wire mem_rd = data_acc & ~pwrite & ptr_live & ~coef_access_direction;
	wire ctrl_wr = wr & hit(paddr, `ICRL_IDX_CTRL);
	wire prog_rise = ctrl_wr & pwdata[`ICRL_CTRL_PROG] & ~coef_program_enable;

	// one write enable per register
	always @* begin
		wr_en = 9'h000;
		case (sel_of(paddr))
		SEL_DATA: wr_en[SEL_DATA] = wr;
		SEL_DELAY: wr_en[SEL_DELAY] = wr;
		SEL_CTRL: wr_en[SEL_CTRL] = wr;
		SEL_SCALE_LO: wr_en[SEL_SCALE_LO] = wr;
		SEL_SCALE_HI: wr_en[SEL_SCALE_HI] = wr;
		SEL_RSVD_A: wr_en[SEL_RSVD_A] = wr;
		SEL_RSVD_B: wr_en[SEL_RSVD_B] = wr;
		SEL_RSVD_C: wr_en[SEL_RSVD_C] = wr;
		SEL_BYPASS: wr_en[SEL_BYPASS] = wr;
		default: wr_en = 9'h000;
		endcase
	end

	// =====================================================
	// software registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			coef_ram_data_port <= `ICRL_RST_DATA;
			path_delay_counts <= `ICRL_RST_DELAY;
			coef_ram_control <= `ICRL_RST_CTRL;
			pcm_scale_low <= `ICRL_RST_SCALE_LO;
			pcm_scale_high <= `ICRL_RST_SCALE_HI;
			reserved_a <= `ICRL_RST_RSVD;
			reserved_b <= `ICRL_RST_RSVD;
			reserved_c <= `ICRL_RST_RSVD;
			filter_bypass_control <= `ICRL_RST_BYPASS;
		end else begin
			// data port holds last byte moved
			if (wr_en[SEL_DATA])
				coef_ram_data_port <= pwdata[7:0];
			else if (mem_rd)
				coef_ram_data_port <= coef_mem[ptr];
			if (wr_en[SEL_DELAY])
				path_delay_counts <= pwdata[7:0];
			if (wr_en[SEL_CTRL])
				coef_ram_control <= pwdata[7:0] & `ICRL_CTRL_MASK;
			if (wr_en[SEL_SCALE_LO])
				pcm_scale_low <= pwdata[7:0];
			if (wr_en[SEL_SCALE_HI])
				pcm_scale_high <= pwdata[7:0];
			if (wr_en[SEL_RSVD_A])
				reserved_a <= pwdata[7:0];
			if (wr_en[SEL_RSVD_B])
				reserved_b <= pwdata[7:0];
			if (wr_en[SEL_RSVD_C])
				reserved_c <= pwdata[7:0];
			if (wr_en[SEL_BYPASS])
				filter_bypass_control <= pwdata[7:0] & `ICRL_BYP_MASK;
		end
	end

	// =====================================================
	// coefficient byte pointer
	always @* begin
		next_ptr = ptr;
		if (prog_rise) begin
			next_ptr = {`ICRL_PTR_W{1'b0}};
		end else if (mem_wr | mem_rd) begin
			next_ptr = ptr + 8'h01;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr <= {`ICRL_PTR_W{1'b0}};
		end else begin
			ptr <= next_ptr;
		end
	end

	// =====================================================
	// coefficient memory
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (i = 0; i < `ICRL_COEF_BYTES; i = i + 1)
				coef_mem[i] <= 8'h00;
		end else if (mem_wr) begin
			coef_mem[ptr] <= pwdata[7:0];
		end
	end

	// port for the matching filter
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			coef_rd_data <= 8'h00;
		else if (coef_rd_addr < `ICRL_COEF_BYTES)
			coef_rd_data <= coef_mem[coef_rd_addr];
		else
			coef_rd_data <= 8'h00;
	end

	// =====================================================
	// read data, captured in the setup cycle
	always @* begin
		next_rdata = 8'h00;
		case (sel_of(paddr))
		SEL_DATA: begin
			if (coef_program_enable & ~coef_access_direction &
				(ptr < `ICRL_COEF_BYTES))
				next_rdata = coef_mem[ptr];
			else
				next_rdata = coef_ram_data_port;
		end
		SEL_DELAY: begin
			next_rdata = path_delay_counts;
		end
		SEL_CTRL: begin
			next_rdata = coef_ram_control;
		end
		SEL_SCALE_LO: begin
			next_rdata = pcm_scale_low;
		end
		SEL_SCALE_HI: begin
			next_rdata = pcm_scale_high;
		end
		SEL_RSVD_A: begin
			next_rdata = reserved_a;
		end
		SEL_RSVD_B: begin
			next_rdata = reserved_b;
		end
		SEL_RSVD_C: begin
			next_rdata = reserved_c;
		end
		SEL_BYPASS: begin
			next_rdata = filter_bypass_control;
		end
		default: begin
			next_rdata = 8'h00;
		end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata <= {24'h00_0000, next_rdata};
		end
	end

	// =====================================================
	// field outputs
	// parallel path delay
	assign parallel_path_delay = path_delay_counts[`ICRL_DLY_PAR_LSB +: 4];
	assign hybrid_path_delay = path_delay_counts[`ICRL_DLY_HYB_LSB +: 4];
	assign pcm_scale_factor = {pcm_scale_high, pcm_scale_low};
	assign hybrid_lpf_bypass = filter_bypass_control[`ICRL_BYP_HYB];
	assign converter_lpf_bypass = filter_bypass_control[`ICRL_BYP_ADC];

	// =====================================================
	// pcm scaling, 3.13 unsigned factor, saturating
	wire signed [16:0] scale_s = {1'b0, pcm_scale_factor};
	wire signed [15:0] pcm_s = pcm_in;
	wire signed [32:0] prod = pcm_s * scale_s;
	wire signed [32:0] shifted = prod >>> `ICRL_SCALE_FRAC;
	wire too_big = (shifted > 33'sd32767);
	wire too_small = (shifted < -33'sd32768);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pcm_out <= 16'h0000;
			pcm_out_valid <= 1'b0;
		end else begin
			pcm_out_valid <= pcm_in_valid;
			if (pcm_in_valid) begin
				if (too_big)
					pcm_out <= 16'h7fff;
				else if (too_small)
					pcm_out <= 16'h8000;
				else
					pcm_out <= shifted[15:0];
			end
		end
	end

endmodule // icrl_loader

`default_nettype wire

/* testbench/icrl_checker.sv */
`default_nettype none
module icrl_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic coef_program_enable,
	input wire logic complex_match_enable,
	input wire logic coef_access_direction,
	input wire logic [3:0] parallel_path_delay,
	input wire logic [3:0] hybrid_path_delay,
	input wire logic [15:0] pcm_scale_factor,
	input wire logic hybrid_lpf_bypass,
	input wire logic converter_lpf_bypass,
	input wire logic [7:0] coef_pointer
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic wr;
	assign wr = psel && penable && pwrite;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================
	// enabled byte write to the data port
	sequence data_wr;
		wr && paddr == 12'h3cc && coef_program_enable &&
			coef_access_direction && coef_pointer < 8'd144;
	endsequence
	// enabled byte read from the data port
	sequence data_rd;
		psel && penable && !pwrite && paddr == 12'h3cc &&
			coef_program_enable && !coef_access_direction &&
			coef_pointer < 8'd144;
	endsequence
	ptr_rd_step_a: assert property (data_rd |=>
		coef_pointer == $past(coef_pointer) + 8'd1) else $error("ptr rd");
	scale_high_a: assert property (wr && paddr == 12'h3dc |=>
		pcm_scale_factor[15:8] == $past(pwdata[7:0])) else $error("scale hi");
	prog_bit_a: assert property (wr && paddr == 12'h3d4 |=>
		coef_program_enable == $past(pwdata[0])) else $error("prog bit");
	match_bit_a: assert property (wr && paddr == 12'h3d4 |=>
		complex_match_enable == $past(pwdata[2])) else $error("match bit");
	dir_bit_a: assert property (wr && paddr == 12'h3d4 |=>
		coef_access_direction == $past(pwdata[4])) else $error("dir bit");
	delay_nibbles_a: assert property (wr && paddr == 12'h3d0 |=>
		{hybrid_path_delay, parallel_path_delay} == $past(pwdata[7:0]))
		else $error("delay");
	scale_low_a: assert property (wr && paddr == 12'h3d8 |=>
		pcm_scale_factor[7:0] == $past(pwdata[7:0])) else $error("scale");
	bypass_bits_a: assert property (wr && paddr == 12'h3ec |=>
		{converter_lpf_bypass, hybrid_lpf_bypass} == $past(pwdata[1:0]))
		else $error("bypass");
	ptr_clear_a: assert property ($rose(coef_program_enable) |->
		coef_pointer == 8'h00) else $error("ptr clear");
	ptr_step_a: assert property (data_wr |=>
		coef_pointer == $past(coef_pointer) + 8'd1) else $error("ptr step");
endmodule // icrl_checker
`default_nettype wire

/* testbench/icrl_loader_tb_top.sv */
`default_nettype none
module icrl_loader_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pcm_in_valid, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] pcm_in, pcm_out, pcm_scale_factor, sc, x;
	logic [7:0] coef_rd_addr, coef_rd_data, coef_pointer, mem [144];
	logic [3:0] parallel_path_delay, hybrid_path_delay;
	logic pready, pslverr, complex_match_enable, coef_program_enable;
	logic coef_access_direction, hybrid_lpf_bypass, converter_lpf_bypass;
	logic pcm_out_valid;
	int num_errors, comparisons;
	icrl_loader dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.coef_rd_addr(coef_rd_addr), .coef_rd_data(coef_rd_data),
		.complex_match_enable(complex_match_enable),
		.coef_program_enable(coef_program_enable),
		.coef_access_direction(coef_access_direction),
		.parallel_path_delay(parallel_path_delay),
		.hybrid_path_delay(hybrid_path_delay),
		.pcm_scale_factor(pcm_scale_factor),
		.hybrid_lpf_bypass(hybrid_lpf_bypass),
		.converter_lpf_bypass(converter_lpf_bypass),
		.coef_pointer(coef_pointer), .pcm_in(pcm_in),
		.pcm_in_valid(pcm_in_valid), .pcm_out(pcm_out),
		.pcm_out_valid(pcm_out_valid));
	task automatic chk(input string n, input logic [31:0] s, xp);
		comparisons++;
		if (s !== xp) begin
			num_errors++;
			$display("BAD %s exp %h got %h", n, xp, s);
		end
	endtask
	task automatic apb(input logic [11:0] a, input logic w, logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	function automatic logic [15:0] scl(input logic [15:0] v, s);
		logic signed [33:0] p;
		p = ($signed(v) * $signed({1'b0, s})) >>> 13;
		if (p > 34'sd32767)
			return 16'h7fff;
		if (p < -34'sd32768)
			return 16'h8000;
		return p[15:0];
	endfunction
	task end_of_test;
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ==========================================
	// clock, watchdog, tests
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		end_of_test();
	end
	initial begin
		{presetn, psel, penable, pwrite, pcm_in_valid} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		pcm_in = 16'h0000;
		coef_rd_addr = 8'h00;
		q = $urandom(32'hb69efb27);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(12'h3d4, 1'b0, 32'h0);
		chk("ctrl_rst", q, 32'h10);
		apb(12'h3ec, 1'b0, 32'h0);
		chk("byp_rst", q, 32'h0);
		apb(12'h3d0, 1'b0, 32'h0);
		chk("dly_rst", q, 32'h0);
		apb(12'h100, 1'b0, 32'h0);
		chk("unmapped", e, 32'h1);
		for (int i = 0; i < 3; i++) begin
			apb(12'h3e0 + 12'(4 * i), 1'b1, 32'h0);
			apb(12'h3e0 + 12'(4 * i), 1'b0, 32'h0);
			chk("rsvd", q, 32'h0);
		end
		x = 16'($urandom);
		apb(12'h3d0, 1'b1, {24'h0, x[7:0]});
		chk("par_dly", parallel_path_delay, x[3:0]);
		chk("hyb_dly", hybrid_path_delay, x[7:4]);
		sc = 16'($urandom) | 16'h8000;
		apb(12'h3d8, 1'b1, {24'h0, sc[7:0]});
		apb(12'h3dc, 1'b1, {24'h0, sc[15:8]});
		chk("scale", pcm_scale_factor, sc);
		for (int i = 0; i < 4; i++) begin
			apb(12'h3ec, 1'b1, 32'(i));
			chk("hyb_byp", hybrid_lpf_bypass, i[0]);
			chk("adc_byp", converter_lpf_bypass, i[1]);
		end
		apb(12'h3d4, 1'b1, 32'h11);
		chk("ptr_clr", coef_pointer, 32'h0);
		for (int i = 0; i < 144; i++) begin
			mem[i] = 8'($urandom);
			apb(12'h3cc, 1'b1, {24'h0, mem[i]});
		end
		chk("ptr_end", coef_pointer, 32'd144);
		apb(12'h3d4, 1'b1, 32'h10);
		apb(12'h3cc, 1'b1, {24'h0, ~mem[0]});
		for (int i = 0; i < 145; i += 36) begin
			coef_rd_addr <= 8'(i);
			repeat (2) @(posedge pclk);
			chk("mem", coef_rd_data, i < 144 ? mem[i] : 8'h00);
		end
		apb(12'h3d4, 1'b1, 32'h00);
		apb(12'h3d4, 1'b1, 32'h01);
		for (int i = 0; i < 144; i++) begin
			apb(12'h3cc, 1'b0, 32'h0);
			chk("rdback", q, {24'h0, mem[i]});
		end
		chk("ptr_rd_end", coef_pointer, 32'd144);
		apb(12'h3d4, 1'b1, 32'h11);
		apb(12'h3d4, 1'b1, 32'h14);
		chk("ctrl", {complex_match_enable, coef_access_direction,
			coef_program_enable}, 32'h6);
		for (int i = 0; i < 8; i++) begin
			pcm_in <= i == 0 ? 16'h8000 : 16'($urandom);
			pcm_in_valid <= 1'b1;
			@(posedge pclk);
			pcm_in_valid <= 1'b0;
			@(negedge pclk);
			chk("pcm", {pcm_out_valid, pcm_out}, {1'b1, scl(pcm_in, sc)});
			@(posedge pclk);
		end
		end_of_test();
	end
endmodule // icrl_loader_tb_top
bind icrl_loader icrl_checker chk_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .coef_program_enable(coef_program_enable),
	.complex_match_enable(complex_match_enable),
	.coef_access_direction(coef_access_direction),
	.parallel_path_delay(parallel_path_delay),
	.hybrid_path_delay(hybrid_path_delay),
	.pcm_scale_factor(pcm_scale_factor),
	.hybrid_lpf_bypass(hybrid_lpf_bypass),
	.converter_lpf_bypass(converter_lpf_bypass),
	.coef_pointer(coef_pointer));
`default_nettype wire
